// [design/cmi_proc_end.sv]
// processor end with its register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module cmi_proc_end
    import cmi_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    cmi_link_if.proc               link,
    input  wire logic [REG_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [REG_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // bus slave state
    logic              aw_have_r, w_have_r, awready_r, wready_r, bvalid_r;
    logic [REG_AW-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic [1:0]        bresp_r, rresp_r;
    logic              arready_r, rvalid_r;
    logic [31:0]       rdata_r;
    // software registers
    logic [31:0]       ctrl_r, addr_r, wdata_r, rdbuf_r;
    logic [ASI_W-1:0]  asi_r;
    logic [MASK_W-1:0] bmask_r;
    logic [ST_W-1:0]   stat_r, imask_r;
    logic              irq_r;
    // request engine and core state
    cmi_req_e          state_r;
    logic              req_valid_r, req_write_r, req_sync_r;
    logic [ASI_W-1:0]  req_asi_r;
    logic [ADDR_W-1:0] req_addr_r;
    logic [MASK_W-1:0] req_mask_r;
    logic [DATA_W-1:0] req_wdata_r;
    logic              mae_r, fence_r, error_r;
    logic [IRL_W-1:0]  irl_meta_r, irl_sync_r;
    logic              pend_r;
    ////////////////////////////////////////////////////////////////////////////////
    // write channel decode
    wire         aw_take  = s_axi_awvalid & awready_r;
    wire         w_take   = s_axi_wvalid & wready_r;
    wire         do_write = aw_have_r & w_have_r & ~bvalid_r;
    wire         aw_nxt   = (aw_have_r & ~do_write) | aw_take;
    wire         w_nxt    = (w_have_r & ~do_write) | w_take;
    wire [31:0]  wbe      = {{8{w_strb_r[3]}},{8{w_strb_r[2]}},{8{w_strb_r[1]}},{8{w_strb_r[0]}}};
    wire [31:0]  wm       = w_data_r & wbe;
    wire         wr_ctrl  = do_write && (aw_addr_r == REG_CTRL);
    wire         wr_addr  = do_write && (aw_addr_r == REG_ADDR);
    wire         wr_asi   = do_write && (aw_addr_r == REG_ASI);
    wire         wr_wdata = do_write && (aw_addr_r == REG_WDATA);
    wire         wr_bmask = do_write && (aw_addr_r == REG_BMASK);
    wire         wr_stat  = do_write && (aw_addr_r == REG_STAT);
    wire         wr_imask = do_write && (aw_addr_r == REG_IMASK);
    wire         wr_cmd   = do_write && (aw_addr_r == REG_CMD);
    wire         wr_ro    = do_write && ((aw_addr_r == REG_RDATA) || (aw_addr_r == REG_INFO));
    wire         wr_hit   = wr_ctrl | wr_addr | wr_asi | wr_wdata | wr_bmask | wr_stat
                            | wr_imask | wr_cmd | wr_ro;

    // core controls and request launch; read and write commands are refused while busy or halted, fence is taken unless a reset request is present
    wire         rst_in   = link.rst_req;
    wire         pso      = ctrl_r[CTRL_PSO_BIT];
    wire         et       = ctrl_r[CTRL_ET_BIT];
    wire [3:0]   pil      = ctrl_r[CTRL_PIL_LSB +: 4];
    wire         idle     = (state_r == REQ_IDLE) & ~error_r & ~rst_in;
    wire         go_rd    = wr_cmd & wm[CMD_READ_BIT] & idle;
    wire         go_wr    = wr_cmd & wm[CMD_WRITE_BIT] & ~wm[CMD_READ_BIT] & idle;
    wire         rsp_ok   = (state_r == REQ_WAIT) & link.rsp_valid;
    wire         enter_err = rsp_ok & link.rsp_mae & ~et;

    // synchronised level only; 15 beats any priority level
    wire         lvl_req  = (irl_sync_r != IRL_NONE);
    wire         lvl_wins = (irl_sync_r == IRL_NMI) | (irl_sync_r > pil);
    wire         pend     = lvl_req & lvl_wins & et & ~error_r;

    // sticky events; a set in the cycle of its clear wins
    wire [ST_W-1:0] st_set = {enter_err, rst_in, pend & ~pend_r,
                              rsp_ok & link.rsp_mae, rsp_ok};
    wire [ST_W-1:0] st_nxt = (stat_r & ~(wr_stat ? wm[ST_W-1:0] : '0)) | st_set;
    // read decode
    wire         ar_take  = s_axi_arvalid & arready_r;
    wire         rd_hit   = (s_axi_araddr <= REG_CMD) && (s_axi_araddr[1:0] == 2'h0);
    wire [31:0]  info     = {20'h0, irl_sync_r, 3'h0, pend_r, error_r, fence_r,
                             mae_r, (state_r != REQ_IDLE)};
    logic [31:0] rd_word;
    always_comb begin
        unique case (s_axi_araddr)
            REG_CTRL:  rd_word = ctrl_r;
            REG_ADDR:  rd_word = addr_r;
            REG_ASI:   rd_word = {24'h0, asi_r};
            REG_WDATA: rd_word = wdata_r;
            REG_BMASK: rd_word = {28'h0, bmask_r};
            REG_RDATA: rd_word = rdbuf_r;
            REG_STAT:  rd_word = {27'h0, stat_r};
            REG_IMASK: rd_word = {27'h0, imask_r};
            REG_INFO:  rd_word = info;
            default:   rd_word = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write: address and data in either order, response after both
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            aw_have_r <= aw_nxt;
            w_have_r  <= w_nxt;
            awready_r <= ~aw_nxt;
            wready_r  <= ~w_nxt;
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // captured address and data, unreset
    always_ff @(posedge ref_clk) begin
        if (aw_take) aw_addr_r <= s_axi_awaddr;
        if (w_take) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
    end
    // read channel: answer one cycle after the address
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= RESP_OKAY;
        end else begin
            arready_r <= ~(ar_take | (rvalid_r & ~s_axi_rready));
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_word;
                rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software registers; reset request restores control
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctrl_r  <= CTRL_RST;
            addr_r  <= '0;
            asi_r   <= ASI_RST;
            wdata_r <= '0;
            bmask_r <= BMASK_RST;
            imask_r <= '0;
            stat_r  <= '0;
            irq_r   <= 1'b0;
        end else begin
            if (rst_in) ctrl_r <= CTRL_RST;
            else if (wr_ctrl) ctrl_r <= ((ctrl_r & ~wbe) | wm) & CTRL_WMASK;
            if (wr_addr) addr_r <= (addr_r & ~wbe) | wm;
            if (wr_asi && w_strb_r[0]) asi_r <= w_data_r[7:0];
            if (wr_wdata) wdata_r <= (wdata_r & ~wbe) | wm;
            if (wr_bmask && w_strb_r[0]) bmask_r <= w_data_r[3:0];
            if (wr_imask && w_strb_r[0]) imask_r <= w_data_r[ST_W-1:0];
            stat_r <= st_nxt;
            irq_r  <= |(st_nxt & imask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request engine: issue, hold until taken, wait for the answer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r     <= REQ_IDLE;
            req_valid_r <= 1'b0;
            mae_r       <= 1'b0;
            rdbuf_r     <= '0;
        end else if (rst_in) begin
            state_r     <= REQ_IDLE;
            req_valid_r <= 1'b0;
        end else begin
            unique case (state_r)
                REQ_IDLE: begin
                    if (go_rd || go_wr) begin
                        state_r     <= REQ_ISSUE;
                        req_valid_r <= 1'b1;
                        req_write_r <= go_wr;
                        // one access at a time, so a sync write follows completed ones
                        req_sync_r  <= go_wr & (fence_r | ~pso);
                        req_asi_r   <= asi_r;
                        req_addr_r  <= addr_r;
                        req_mask_r  <= go_wr ? bmask_r : '0;
                        req_wdata_r <= wdata_r;
                    end
                end
                REQ_ISSUE: begin
                    if (link.req_ready) begin
                        state_r     <= REQ_WAIT;
                        req_valid_r <= 1'b0;
                    end
                end
                REQ_WAIT: begin
                    if (link.rsp_valid) begin
                        state_r <= REQ_IDLE;
                        mae_r   <= link.rsp_mae;
                        if (!req_write_r) rdbuf_r <= link.rsp_rdata;
                    end
                end
            endcase
        end
    end

    // fence, halt state and interrupt level synchroniser
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            fence_r    <= 1'b0;
            error_r    <= 1'b0;
            irl_meta_r <= IRL_NONE;
            irl_sync_r <= IRL_NONE;
            pend_r     <= 1'b0;
        end else begin
            irl_meta_r <= link.irl;
            irl_sync_r <= irl_meta_r;
            pend_r     <= pend;
            if (rst_in) begin
                fence_r <= 1'b0;
                error_r <= 1'b0;
            end else begin
                if (wr_cmd && wm[CMD_FENCE_BIT]) fence_r <= 1'b1;
                else if (rsp_ok && req_sync_r) fence_r <= 1'b0;
                if (enter_err) error_r <= 1'b1;
            end
        end
    end

    assign s_axi_awready  = awready_r;
    assign s_axi_wready   = wready_r;
    assign s_axi_bvalid   = bvalid_r;
    assign s_axi_bresp    = bresp_r;
    assign s_axi_arready  = arready_r;
    assign s_axi_rvalid   = rvalid_r;
    assign s_axi_rdata    = rdata_r;
    assign s_axi_rresp    = rresp_r;
    assign irq            = irq_r;
    assign link.req_valid = req_valid_r;
    assign link.req_write = req_write_r;
    assign link.req_sync  = req_sync_r;
    assign link.req_asi   = req_asi_r;
    assign link.req_addr  = req_addr_r;
    assign link.req_mask  = req_mask_r;
    assign link.req_wdata = req_wdata_r;
    assign link.err_ind   = error_r;
endmodule

// [shared/cmi_pkg.sv]
// shared constants and types for the link
package cmi_pkg;
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 32;
    localparam int          ASI_W         = 8;
    localparam int          MASK_W        = 4;
    localparam int          IRL_W         = 4;
    localparam int          REG_AW        = 8;
    localparam logic [3:0]  IRL_NONE      = 4'h0;
    localparam logic [3:0]  IRL_NMI       = 4'hf;

    // register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_ADDR      = 8'h04;
    localparam logic [7:0]  REG_ASI       = 8'h08;
    localparam logic [7:0]  REG_WDATA     = 8'h0c;
    localparam logic [7:0]  REG_BMASK     = 8'h10;
    localparam logic [7:0]  REG_RDATA     = 8'h14;
    localparam logic [7:0]  REG_STAT      = 8'h18;
    localparam logic [7:0]  REG_IMASK     = 8'h1c;
    localparam logic [7:0]  REG_INFO      = 8'h20;
    localparam logic [7:0]  REG_CMD       = 8'h24;

    // control fields
    localparam int          CTRL_PSO_BIT  = 0;
    localparam int          CTRL_ET_BIT   = 1;
    localparam int          CTRL_PIL_LSB  = 4;
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK    = 32'h0000_00f3;

    // command bits, write-only pulses
    localparam int          CMD_READ_BIT  = 0;
    localparam int          CMD_WRITE_BIT = 1;
    localparam int          CMD_FENCE_BIT = 2;

    // sticky status and mask layout
    localparam int          ST_W          = 5;
    localparam int          ST_DONE       = 0;
    localparam int          ST_MAE        = 1;
    localparam int          ST_IRQ        = 2;
    localparam int          ST_RST        = 3;
    localparam int          ST_ERR        = 4;

    // live information fields
    localparam int          INF_BUSY      = 0;
    localparam int          INF_MAE       = 1;
    localparam int          INF_FENCE     = 2;
    localparam int          INF_ERR       = 3;
    localparam int          INF_PEND      = 4;
    localparam int          INF_IRL_LSB   = 8;

    localparam logic [7:0]  ASI_RST       = 8'h0b;
    localparam logic [3:0]  BMASK_RST     = 4'hf;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // memory end defaults
    localparam int          MEM_DEPTH     = 256;
    localparam int          MEM_LAT       = 2;
    localparam logic [7:0]  ASI_USER_DATA = 8'h0a;
    localparam logic [7:0]  ASI_SUPV_DATA = 8'h0b;

    typedef enum logic [1:0] {REQ_IDLE, REQ_ISSUE, REQ_WAIT} cmi_req_e;
    typedef enum logic [1:0] {MEM_IDLE, MEM_BUSY, MEM_ANSWER} cmi_mem_e;
endpackage

// [shared/cmi_link_if.sv]
// link between the processor end and the memory system end
`timescale 1ns/100ps
interface cmi_link_if;
    import cmi_pkg::*;
    logic              req_valid;
    logic              req_ready;
    logic              req_write;
    logic              req_sync;
    logic [ASI_W-1:0]  req_asi;
    logic [ADDR_W-1:0] req_addr;
    logic [MASK_W-1:0] req_mask;
    logic [DATA_W-1:0] req_wdata;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;
    logic              rsp_mae;
    logic [IRL_W-1:0]  irl;
    logic              rst_req;
    logic              err_ind;

    modport proc (
        output req_valid, req_write, req_sync, req_asi, req_addr, req_mask, req_wdata,
        output err_ind,
        input  req_ready, rsp_valid, rsp_rdata, rsp_mae, irl, rst_req
    );
    modport sys (
        input  req_valid, req_write, req_sync, req_asi, req_addr, req_mask, req_wdata,
        input  err_ind,
        output req_ready, rsp_valid, rsp_rdata, rsp_mae, irl, rst_req
    );
endinterface

// [design/cmi_mem_end.sv]
// memory end: word store, access checks, level and reset drivers
`timescale 1ns/100ps
module cmi_mem_end
    import cmi_pkg::*;
#(
    parameter int         DEPTH = MEM_DEPTH,
    parameter int         LAT   = MEM_LAT,
    parameter logic [7:0] ASI_A = ASI_USER_DATA,
    parameter logic [7:0] ASI_B = ASI_SUPV_DATA
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    cmi_link_if.sys               link,
    input  wire logic [IRL_W-1:0] irl_level,
    input  wire logic             ext_reset,
    output logic                  error_seen
);
    localparam int IDX_W = $clog2(DEPTH);
    localparam logic [7:0] LAT_M1 = 8'(LAT - 1);

    cmi_mem_e          state_r;
    logic [7:0]        cnt_r;
    logic              ready_r;
    logic              rsp_valid_r;
    logic [DATA_W-1:0] rsp_rdata_r;
    logic              rsp_mae_r;
    logic              write_r;
    logic [ASI_W-1:0]  asi_r;
    logic [ADDR_W-1:0] addr_r;
    logic [MASK_W-1:0] mask_r;
    logic [DATA_W-1:0] wdata_r;
    logic [IRL_W-1:0]  irl_r;
    logic              rst_r;
    logic              err_r;
    logic [DATA_W-1:0] mem_r [DEPTH];

    // access checks: wrong space, misaligned word or outside the store excepts
    wire              asi_ok   = (asi_r == ASI_A) || (asi_r == ASI_B);
    wire              align_ok = (addr_r[1:0] == 2'h0);
    wire              range_ok = (addr_r[ADDR_W-1:2] < 30'(DEPTH));
    wire              acc_ok   = asi_ok & align_ok & range_ok;
    wire [IDX_W-1:0]  idx      = addr_r[IDX_W+1:2];
    wire              take     = link.req_valid & ready_r;
    wire              fire     = (state_r == MEM_BUSY) && (cnt_r == 8'h0);

    // one request in flight, answered in arrival order
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r     <= MEM_IDLE;
            cnt_r       <= 8'h0;
            ready_r     <= 1'b0;
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= 1'b0;
            unique case (state_r)
                MEM_IDLE: begin
                    ready_r <= ~take;
                    if (take) begin
                        state_r <= MEM_BUSY;
                        cnt_r   <= LAT_M1;
                    end
                end
                MEM_BUSY: begin
                    if (fire) begin
                        // strictly in order, so sync writes are met
                        state_r     <= MEM_ANSWER;
                        rsp_valid_r <= 1'b1;
                        rsp_mae_r   <= ~acc_ok;
                        rsp_rdata_r <= (!write_r && acc_ok) ? mem_r[idx] : '0;
                    end else begin
                        cnt_r <= cnt_r - 8'h1;
                    end
                end
                MEM_ANSWER: begin
                    state_r <= MEM_IDLE;
                    ready_r <= 1'b1;
                end
            endcase
        end
    end

    // request capture, unreset: read only after a take
    always_ff @(posedge ref_clk) begin
        if (take) begin
            write_r <= link.req_write;
            asi_r   <= link.req_asi;
            addr_r  <= link.req_addr;
            mask_r  <= link.req_mask;
            wdata_r <= link.req_wdata;
        end
    end

    // byte lanes: mask msb is byte 0 (bits 31:24); an excepting write changes nothing
    always_ff @(posedge ref_clk) begin
        if (fire && write_r && acc_ok) begin
            for (int b = 0; b < MASK_W; b++) begin
                if (mask_r[MASK_W-1-b]) begin
                    mem_r[idx][DATA_W-1-8*b -: 8] <= wdata_r[DATA_W-1-8*b -: 8];
                end
            end
        end
    end

    // level, reset and error flops
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irl_r <= IRL_NONE;
            rst_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            irl_r <= irl_level;
            rst_r <= ext_reset;
            err_r <= link.err_ind;
        end
    end

    assign link.req_ready = ready_r;
    assign link.rsp_valid = rsp_valid_r;
    assign link.rsp_rdata = rsp_rdata_r;
    assign link.rsp_mae   = rsp_mae_r;
    assign link.irl       = irl_r;
    assign link.rst_req   = rst_r;
    assign error_seen     = err_r;
endmodule

// [tb/cmi_link_sva.sv]
// concurrent checks on the processor to memory link
`timescale 1ns/100ps
module cmi_link_sva
    import cmi_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire logic              req_write,
    input wire logic              req_sync,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic              rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic              rsp_mae,
    input wire logic              rst_req,
    input wire logic              err_ind
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////////
    // a reset request may withdraw a pending request, nothing else may
    chk_req_hold: assert property (req_valid && !req_ready |=> rst_req ||
        (req_valid && $stable(req_addr) && $stable(req_wdata))) else $error("request moved");
    chk_rsp_latency: assert property (req_valid && req_ready |-> ##[2:3] rsp_valid)
        else $error("answer late");
    chk_busy_ready: assert property (req_valid && req_ready |=> !req_ready [*2])
        else $error("second request taken");
    chk_no_overlap: assert property (rsp_valid |-> !req_valid)
        else $error("request during answer");
    chk_mae_data: assert property (rsp_valid && rsp_mae |-> rsp_rdata == '0)
        else $error("data on exception");
    chk_sync_write: assert property (req_valid && !req_write |-> !req_sync)
        else $error("sync on read");
    chk_err_hold: assert property (err_ind && !rst_req |=> err_ind)
        else $error("error dropped");
    chk_err_cause: assert property ($rose(err_ind) |-> $past(rsp_valid) && $past(rsp_mae))
        else $error("error without exception");
    chk_rst_clear: assert property (rst_req |=> !err_ind && !req_valid)
        else $error("reset request ignored");
    cover property (req_valid && req_ready && req_write);
    cover property (rsp_valid && rsp_mae);
    cover property ($rose(err_ind));
endmodule

// [tb/cpu_memory_irq_reset_interface_tb.sv]
// self-checking bench for both link ends
`timescale 1ns/100ps
`define CK(n, e, s) begin tests_run++; if ((e) !== (s)) begin mismatches++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module cpu_memory_irq_reset_interface_tb
    import cmi_pkg::*;
;
    logic        ref_clk = 1'b0, resetn = 1'b0, ext_reset = 1'b0, error_seen, irq;
    logic [3:0]  irl_level = 4'h0, s_axi_wstrb = 4'hf, m;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, ea, eb, ad;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] lf = 16'h534c;
    int          mismatches = 0, tests_run = 0;
    logic [12:0] tbl [6] = '{{8'h52, 4'h3, 1'b0}, {8'h52, 4'h6, 1'b1}, {8'hf2, 4'hf, 1'b1},
                             {8'hf2, 4'he, 1'b0}, {8'hf0, 4'hf, 1'b0}, {8'h02, 4'h0, 1'b0}};

    ////////////////////////////////////////////////////////////////////////////////
    cmi_link_if lk ();
    cmi_mem_end u_cmi_mem_end (.ref_clk, .resetn, .link(lk), .irl_level, .ext_reset,
        .error_seen);
    cmi_proc_end u_cmi_proc_end (.ref_clk, .resetn, .link(lk), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    cmi_link_sva u_cmi_link_sva (.ref_clk, .resetn, .req_valid(lk.req_valid),
        .req_ready(lk.req_ready), .req_write(lk.req_write), .req_sync(lk.req_sync),
        .req_addr(lk.req_addr), .req_wdata(lk.req_wdata), .rsp_valid(lk.rsp_valid),
        .rsp_rdata(lk.rsp_rdata), .rsp_mae(lk.rsp_mae), .rst_req(lk.rst_req),
        .err_ind(lk.err_ind));

    // free-running bench clock
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // expected word after a lane-masked store
    function automatic logic [31:0] merge(input logic [31:0] a, b, input logic [3:0] k);
        for (int j = 0; j < 4; j++)
            if (k[j]) a[8*j +: 8] = b[8*j +: 8];
        return a;
    endfunction
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic lim(input int n);
        if (n >= 50) begin
            mismatches++;
            print_verdict();
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        lim(n);
    endtask
    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge ref_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        lim(n);
    endtask
    task automatic idle();
        int n;
        for (n = 0; n < 50; n++) begin
            axr(REG_INFO);
            if (rd[INF_BUSY] === 1'b0) break;
        end
        lim(n);
    endtask
    task automatic mw(input logic [31:0] a, d, input logic [3:0] k);
        axw(REG_ADDR, a);
        axw(REG_WDATA, d);
        axw(REG_BMASK, {28'h0, k});
        axw(REG_CMD, 32'h2);
        idle();
    endtask
    task automatic mr(input logic [31:0] a);
        axw(REG_ADDR, a);
        axw(REG_CMD, 32'h1);
        idle();
        axr(REG_RDATA);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // stores, exceptions, fence, levels, halt, reset
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        axr(REG_ASI);
        `CK("asi", ASI_RST, rd[7:0])
        for (int i = 0; i < 4; i++) begin
            lf = nx(nx(lf));
            ad = {22'h0, lf[7:0], 2'h0};
            ea = {lf, nx(lf)};
            eb = ~{nx(lf), lf};
            m  = (i == 0) ? 4'h8 : (i == 1) ? 4'h1 : lf[11:8];
            mw(ad, ea, 4'hf);
            mw(ad, eb, m);
            mr(ad);
            `CK("rdata", merge(ea, eb, m), rd)
        end
        axw(REG_CTRL, 32'h2);
        axw(REG_ASI, 32'h33);
        mw(ad, ~ea, 4'hf);
        axr(REG_INFO);
        `CK("mae", 1'b1, rd[INF_MAE])
        axw(REG_ASI, {24'h0, ASI_RST});
        mr(ad);
        `CK("kept", merge(ea, eb, m), rd)
        axr(REG_INFO);
        `CK("mae", 1'b0, rd[INF_MAE])
        mr(32'h1001);
        axr(REG_INFO);
        `CK("mae", 1'b1, rd[INF_MAE])
        axw(REG_CMD, 32'h4);
        axr(REG_INFO);
        `CK("fence", 1'b1, rd[INF_FENCE])
        mw(ad, ea, 4'hf);
        axr(REG_INFO);
        `CK("fence", 1'b0, rd[INF_FENCE])
        axw(REG_IMASK, 32'h4);
        axw(REG_STAT, 32'h1f);
        for (int i = 0; i < 6; i++) begin
            irl_level <= tbl[i][4:1];
            axw(REG_CTRL, {24'h0, tbl[i][12:5]});
            axr(REG_INFO);
            `CK("pend", tbl[i][0], rd[INF_PEND])
            `CK("level", tbl[i][4:1], rd[11:8])
            if (i < 2) `CK("irq", tbl[i][0], irq)
            axw(REG_STAT, 32'h1f);
            repeat (2) @(posedge ref_clk);
            `CK("irq", 1'b0, irq)
        end
        axw(REG_CTRL, 32'h1);
        mr(32'h1001);
        axr(REG_INFO);
        `CK("halt", 1'b1, rd[INF_ERR])
        `CK("err", 1'b1, error_seen)
        ext_reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ext_reset <= 1'b0;
        axr(REG_INFO);
        `CK("halt", 1'b0, rd[INF_ERR])
        `CK("err", 1'b0, error_seen)
        axr(REG_CTRL);
        `CK("ctrl", 32'h0, rd)
        axr(8'h40);
        `CK("resp", RESP_SLVERR, rr)
        axw(8'h42, 32'h0);
        `CK("bresp", RESP_SLVERR, rr)
        print_verdict();
    end
endmodule
